// File: pkg/scmd_cfg.svh
`ifndef SCMD_CFG_SVH
`define SCMD_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define SCMD_CFG_INDEX   14'h1F01
`define SCMD_SR1_INDEX   14'h1F09
`define SCMD_SR1_FAST_BIT 6
`define SCMD_SR1_RESET   8'h40
`define SCMD_CFG_PRELOAD 8'hFF

`define SCMD_FETCH_ADDR  24'h00FFF9
`define SCMD_PRAM_HI     24'h000FFF
`define SCMD_IO_LO       24'h001E00
`define SCMD_IO_HI       24'h001FFF
`define SCMD_BOOT_LO     24'h002000
`define SCMD_BOOT_HI     24'h0023FF
`define SCMD_PROM_LO     24'h002400
`define SCMD_PROM_HI     24'h019FFF
`define SCMD_TEXT_LO     24'h0A0000
`define SCMD_TEXT_HI     24'h0A3FFF

// Counts in oscillator periods.
`define SCMD_SLOW_DIV    256
`define SCMD_RST_LONG    4095
`define SCMD_RST_SHORT   16
`define SCMD_EXT_WAIT    4

`endif

// File: pkg/scmd_pkg.sv
`include "scmd_cfg.svh"
package scmd_pkg;
   typedef struct packed {
      logic long_reset_select;
      logic test_pin_toggle_enable;
      logic external_bus_quiet;
      logic multifunction_pin_mode;
      logic test_rom_disable;
      logic internal_rom_enable;
      logic internal_ram_enable;
      logic internal_cpu_enable;
   } scmd_cfg_t;

   typedef enum logic [2:0] {
      SEG_EXT  = 3'b000,
      SEG_PRAM = 3'b001,
      SEG_IO   = 3'b010,
      SEG_BOOT = 3'b011,
      SEG_PROM = 3'b100,
      SEG_TROM = 3'b101,
      SEG_TEXT = 3'b110
   } scmd_seg_t;

   typedef enum logic [1:0] {
      FS_WAIT = 2'b00,
      FS_REQ  = 2'b01,
      FS_READ = 2'b10,
      FS_DONE = 2'b11
   } scmd_fetch_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0]  data;
      logic        data_oe_n;
      logic        write_strobe_n;
      logic        output_enable_n;
      logic        strobe_oe_n;
   } scmd_ext_pins_t;

   function automatic scmd_seg_t scmd_decode(input logic [23:0] a, input scmd_cfg_t c,
                                             input logic tram);
      scmd_seg_t s;
      s = SEG_EXT;
      if (c.internal_ram_enable && a <= `SCMD_PRAM_HI) s = SEG_PRAM;
      else if (a >= `SCMD_IO_LO && a <= `SCMD_IO_HI) s = SEG_IO;
      else if (c.internal_rom_enable && a >= `SCMD_BOOT_LO && a <= `SCMD_BOOT_HI) s = SEG_BOOT;
      else if (c.internal_rom_enable && a >= `SCMD_PROM_LO && a <= `SCMD_PROM_HI)
         s = c.test_rom_disable ? SEG_PROM : SEG_TROM;
      else if (tram && a >= `SCMD_TEXT_LO && a <= `SCMD_TEXT_HI) s = SEG_TEXT;
      return s;
   endfunction
endpackage

// File: rtl/scmd_slow_div.sv
`timescale 1ns/100ps
`include "scmd_cfg.svh"
module scmd_slow_div import scmd_pkg::*; #(
   parameter int DIV = `SCMD_SLOW_DIV
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic fast_i,
   output logic      cpu_clk_en_o,
   output logic      slow_active_o
);
   localparam int W = $clog2(DIV);

   if (DIV < 2 || (1 << W) != DIV) begin : g_chk
      $error("DIV must be a power of two of at least 2");
   end

   logic [W-1:0] cnt_reg, cnt_next;
   logic         slow_reg, slow_next;
   logic         wrap;

   assign wrap = (cnt_reg == {W{1'b1}});

   always_comb begin
      cnt_next = cnt_reg + 1'b1;
      slow_next = slow_reg;
      if (fast_i) slow_next = 1'b0;
      else if (wrap) slow_next = 1'b1; // R22
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg  <= '0;
         slow_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         slow_reg <= slow_next;
      end
   end

   // One enable per DIV periods in slow mode; fast flag bypasses the register at once.
   assign cpu_clk_en_o  = fast_i | ~slow_reg | wrap; // R1 R5
   assign slow_active_o = slow_reg;

   a_slow_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
      (slow_reg && !fast_i && cpu_clk_en_o) |=> (!cpu_clk_en_o || fast_i) [*8])
      else $error("slow enable came early");
   a_fast_now: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
      fast_i |-> cpu_clk_en_o)
      else $error("fast flag did not give full rate");
   a_slow_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
      $fell(fast_i) |-> ##[0:256] (slow_reg || fast_i))
      else $error("slow mode took too long");
endmodule

// File: rtl/scmd_rst_pulse.sv
`timescale 1ns/100ps
`include "scmd_cfg.svh"
module scmd_rst_pulse import scmd_pkg::*; #(
   parameter int LONG  = `SCMD_RST_LONG,
   parameter int SHORT = `SCMD_RST_SHORT
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic trigger_i,
   input  wire logic test_pin_i,
   input  wire logic long_sel_i,
   output logic      drive_o
);
   if (LONG < 1 || LONG > 4095 || SHORT < 1 || SHORT > LONG) begin : g_chk
      $error("pulse lengths must lie in 1..4095 with SHORT not above LONG");
   end

   logic        pend_reg, pend_next;
   logic        first_reg, first_next;
   logic        act_reg, act_next;
   logic        long_reg, long_next;
   logic [11:0] cnt_reg, cnt_next;
   logic [11:0] hcnt_reg, hcnt_next;
   logic        start;
   logic        use_long;
   logic [1:0]  settle_reg, settle_next;

   // Test pin low forces long; test pin high makes the first pulse short.
   assign use_long = !test_pin_i || (!first_reg && long_sel_i); // R14
   // The power-on pulse waits until the synchronised test pin has settled.
   assign start    = !act_reg && ((pend_reg && settle_reg == 2'b10) || trigger_i);

   always_comb begin
      pend_next  = pend_reg;
      first_next = first_reg;
      act_next   = act_reg;
      long_next  = long_reg;
      cnt_next   = cnt_reg;
      hcnt_next  = act_reg ? hcnt_reg + 12'h001 : hcnt_reg;
      settle_next = (settle_reg == 2'b10) ? settle_reg : settle_reg + 2'b01;
      if (start) begin
         pend_next  = 1'b0;
         first_next = 1'b0;
         act_next   = 1'b1;
         long_next  = use_long;
         cnt_next   = use_long ? LONG[11:0] - 12'h001 : SHORT[11:0] - 12'h001; // R13
         hcnt_next  = 12'h000;
      end else if (act_reg) begin
         if (cnt_reg == 12'h000) act_next = 1'b0;
         else cnt_next = cnt_reg - 12'h001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_reg  <= 1'b1;
         first_reg <= 1'b1;
         act_reg   <= 1'b0;
         long_reg  <= 1'b0;
         cnt_reg   <= 12'h000;
         hcnt_reg  <= 12'h000;
         settle_reg <= 2'b00;
      end else begin
         pend_reg  <= pend_next;
         first_reg <= first_next;
         act_reg   <= act_next;
         long_reg  <= long_next;
         cnt_reg   <= cnt_next;
         hcnt_reg  <= hcnt_next;
         settle_reg <= settle_next;
      end
   end

   assign drive_o = act_reg;

   a_pulse_len: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
      $fell(act_reg) |-> (hcnt_reg == (long_reg ? LONG[11:0] : SHORT[11:0])))
      else $error("reset pulse length wrong");
   a_long_testlow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
      (start && !test_pin_i) |=> long_reg)
      else $error("test pin low did not give long pulse");
endmodule

// File: rtl/scmd_top.sv
// Operation
// R1: Slow mode runs the processor at one 256th of its normal rate.
// R2: Only processor, interrupts, RAM, ROM, DMA and watchdog are slowed.
// R3: Every reset leaves the processor clock in fast mode.
// R4: Clearing the fast flag slows the processor within 256 oscillator periods.
// R5: Setting the fast flag restores full rate at once.
// R6: The whole subsystem runs on the oscillator clock, half the crystal rate.
// R7: Reset never clears or alters RAM contents.
// R8: Addresses outside enabled internal segments go to the external bus.
// R9: Where internal and external overlap, the internal memory is chosen.
// R10: External data and strobes float during internal accesses by default.
// R11: Each rising reset pin edge loads the byte at 00FFF9h into configuration.
// R12: Test pin low fetches from mask ROM, high from external memory.
// R13: Reset pin pulse lasts 4095 periods with long reset, else 16.
// R14: Test high makes first pulse short; test low makes every pulse long.
// R15: With toggle enabled, the test pin switches multifunction pins bus/normal.
// R16: Configuration holds eight read/write bits, long reset down to cpu enable.
// R17: RAM and ROM enable bits drop those segments to external memory.
// R18: Quiet bit set floats external pins on internal access; clear drives them.
// R19: Processor, RAM and ROM enable bits enable when one, disable when zero.
// R20: ROM enable with test-ROM disable picks CPU ROM, else test ROM or external.
// R21: The processor stays in reset until the configuration byte is loaded.
// R22: The slow divider is a free-running counter switching at its wrap.
`timescale 1ns/100ps
`include "scmd_cfg.svh"
module scmd_top import scmd_pkg::*; #(
   parameter int EXT_WAIT = `SCMD_EXT_WAIT,
   parameter int SLOW_DIV = `SCMD_SLOW_DIV
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [15:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        reset_pin_n_i,
   output logic             reset_pin_n_o,
   output logic             reset_pin_drive_n_o,
   input  wire logic        test_pin_i,
   input  wire logic        int_reset_req_i,
   input  wire logic        text_ram_enable_i,
   input  wire logic [23:0] cpu_addr_i,
   input  wire logic        cpu_rd_i,
   input  wire logic        cpu_wr_i,
   input  wire logic [7:0]  cpu_wdata_i,
   input  wire logic [7:0]  boot_rom_data_i,
   output logic             boot_rom_rd_o,
   output logic [23:0]      boot_rom_addr_o,
   input  wire logic [7:0]  ext_data_bus_i,
   output scmd_ext_pins_t   ext_pins_o,
   output scmd_seg_t        mem_select_o,
   output scmd_cfg_t        cfg_o,
   output logic             cpu_rst_n_o,
   output logic             cpu_enable_o,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             mf_bus_mode_o
);
   if (EXT_WAIT < 3 || EXT_WAIT > 7) begin : g_chk
      $error("EXT_WAIT must lie in 3..7");
   end

   // Pin synchronisers; the reset pin idles high, so its stages reset high.
   logic       rpin_s1, rpin_s2, rpin_s3;
   logic       test_s1, test_s2;
   logic [7:0] ext_s1, ext_s2;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rpin_s1 <= 1'b1;
         rpin_s2 <= 1'b1;
         rpin_s3 <= 1'b1;
         test_s1 <= 1'b0;
         test_s2 <= 1'b0;
         ext_s1  <= 8'h00;
         ext_s2  <= 8'h00;
      end else begin
         rpin_s1 <= reset_pin_n_i;
         rpin_s2 <= rpin_s1;
         rpin_s3 <= rpin_s2;
         test_s1 <= test_pin_i;
         test_s2 <= test_s1;
         ext_s1  <= ext_data_bus_i;
         ext_s2  <= ext_s1;
      end
   end

   // Register bus decode.
   logic hit_cfg, hit_sr1, hit_any;
   logic apb_setup, apb_wr;

   assign hit_cfg   = (paddr_i[15:2] == `SCMD_CFG_INDEX) && (paddr_i[1:0] == 2'b00);
   assign hit_sr1   = (paddr_i[15:2] == `SCMD_SR1_INDEX) && (paddr_i[1:0] == 2'b00);
   assign hit_any   = hit_cfg | hit_sr1;
   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr    = psel_i & penable_i & pwrite_i & hit_any;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;

   // Configuration fetch and register state.
   scmd_fetch_t state_reg, state_next;
   scmd_cfg_t   system_configuration_reg, system_configuration_next;
   logic [7:0]  standby_reg_one_reg, standby_reg_one_next;
   logic [2:0]  wait_reg, wait_next;
   logic        src_ext_reg, src_ext_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [7:0]  fetch_data;
   logic        cpu_fast_flag;
   logic        fetching_ext;

   assign fetch_data    = src_ext_reg ? ext_s2 : boot_rom_data_i; // R12
   assign cpu_fast_flag = standby_reg_one_reg[`SCMD_SR1_FAST_BIT];
   assign fetching_ext  = src_ext_reg && (state_reg == FS_REQ || state_reg == FS_READ);

   always_comb begin
      state_next                = state_reg;
      wait_next                 = wait_reg;
      src_ext_next              = src_ext_reg;
      system_configuration_next = system_configuration_reg;
      standby_reg_one_next      = standby_reg_one_reg;
      boot_rom_rd_o             = 1'b0;
      prdata_next               = prdata_reg;
      if (apb_setup) begin
         prdata_next = 32'h0000_0000;
         if (hit_cfg) prdata_next = {24'h00_0000, system_configuration_reg};
         if (hit_sr1) prdata_next = {24'h00_0000, standby_reg_one_reg};
      end
      if (apb_wr && hit_cfg) system_configuration_next = scmd_cfg_t'(pwdata_i[7:0]); // R16
      if (apb_wr && hit_sr1) standby_reg_one_next = pwdata_i[7:0];
      // A reset on the pin puts the processor clock back in fast mode.
      if (!rpin_s2) standby_reg_one_next = `SCMD_SR1_RESET; // R3
      unique case (state_reg)
         FS_WAIT: begin
            // The pin must be seen low first, so a pin high through reset is no edge.
            if (rpin_s2 && !rpin_s3) begin
               state_next   = FS_REQ; // R11
               src_ext_next = test_s2; // R12
            end
         end
         FS_REQ: begin
            state_next    = FS_READ;
            wait_next     = src_ext_reg ? EXT_WAIT[2:0] : 3'h0;
            boot_rom_rd_o = ~src_ext_reg; // R12
         end
         FS_READ: begin
            if (wait_reg == 3'h0) begin
               system_configuration_next = scmd_cfg_t'(fetch_data); // R11
               state_next                = FS_DONE;
            end else begin
               wait_next = wait_reg - 3'h1;
            end
         end
         FS_DONE: begin
            state_next = FS_DONE;
         end
      endcase
      if (!rpin_s2) state_next = FS_WAIT;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg                <= FS_WAIT;
         wait_reg                 <= 3'h0;
         src_ext_reg              <= 1'b0;
         system_configuration_reg <= scmd_cfg_t'(`SCMD_CFG_PRELOAD);
         standby_reg_one_reg      <= `SCMD_SR1_RESET; // R3
         prdata_reg               <= 32'h0000_0000;
      end else begin
         state_reg                <= state_next;
         wait_reg                 <= wait_next;
         src_ext_reg              <= src_ext_next;
         system_configuration_reg <= system_configuration_next;
         standby_reg_one_reg      <= standby_reg_one_next;
         prdata_reg               <= prdata_next;
      end
   end

   assign prdata_o        = prdata_reg;
   assign boot_rom_addr_o = `SCMD_FETCH_ADDR;
   assign cfg_o           = system_configuration_reg;
   assign cpu_rst_n_o     = (state_reg == FS_DONE); // R21
   assign cpu_enable_o    = system_configuration_reg.internal_cpu_enable; // R19

   // Multifunction pins fall to bus mode unless normal mode or a test-pin toggle says otherwise.
   assign mf_bus_mode_o = ~system_configuration_reg.multifunction_pin_mode &
      ~(system_configuration_reg.test_pin_toggle_enable & test_s2); // R15

   // Address decode; RAM selects carry no reset term so storage survives reset.
   scmd_seg_t seg;
   assign seg          = scmd_decode(cpu_addr_i, system_configuration_reg,
                                     text_ram_enable_i); // R8 R9 R17 R19 R20
   assign mem_select_o = seg; // R7

   // External pin drive.
   scmd_ext_pins_t pins_reg, pins_next;
   logic           internal_quiet;

   assign internal_quiet = (seg != SEG_EXT) && system_configuration_reg.external_bus_quiet;

   always_comb begin
      pins_next.addr            = cpu_addr_i;
      pins_next.data            = cpu_wdata_i;
      pins_next.data_oe_n       = ~cpu_wr_i;
      pins_next.write_strobe_n  = ~cpu_wr_i;
      pins_next.output_enable_n = ~cpu_rd_i;
      pins_next.strobe_oe_n     = 1'b0;
      if (fetching_ext) begin
         pins_next.addr            = `SCMD_FETCH_ADDR; // R12
         pins_next.data_oe_n       = 1'b1;
         pins_next.write_strobe_n  = 1'b1;
         pins_next.output_enable_n = 1'b0;
      end else if (!cpu_rst_n_o) begin
         pins_next.data_oe_n       = 1'b1;
         pins_next.write_strobe_n  = 1'b1;
         pins_next.output_enable_n = 1'b1;
      end else if (internal_quiet) begin
         pins_next.data_oe_n   = 1'b1; // R10 R18
         pins_next.strobe_oe_n = 1'b1; // R10 R18
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pins_reg <= '{addr: 24'h00_0000, data: 8'h00, data_oe_n: 1'b1,
                       write_strobe_n: 1'b1, output_enable_n: 1'b1, strobe_oe_n: 1'b0};
      end else begin
         pins_reg <= pins_next;
      end
   end

   assign ext_pins_o = pins_reg;

   // Clocks: clk_i is the oscillator clock; only the processor group gets the slowed enable.
   scmd_slow_div #(
      .DIV (SLOW_DIV)
   ) u_scmd_slow_div (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n_i),
      .fast_i        (cpu_fast_flag),
      .cpu_clk_en_o  (cpu_clk_en_o), // R1 R6
      .slow_active_o ()
   );
   assign periph_clk_en_o = 1'b1; // R2

   // Reset pin pulse generator; the pin is open drain, pulled low while driven.
   logic pulse_drive;

   scmd_rst_pulse #(
      .LONG  (`SCMD_RST_LONG),
      .SHORT (`SCMD_RST_SHORT)
   ) u_scmd_rst_pulse (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .trigger_i  (int_reset_req_i),
      .test_pin_i (test_s2),
      .long_sel_i (system_configuration_reg.long_reset_select),
      .drive_o    (pulse_drive)
   );
   assign reset_pin_n_o       = 1'b0;
   assign reset_pin_drive_n_o = ~pulse_drive; // R13

   a_int_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
      (system_configuration_reg.internal_ram_enable && cpu_addr_i <= `SCMD_PRAM_HI)
      |-> (mem_select_o == SEG_PRAM))
      else $error("internal RAM not chosen");
   a_ram_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
      (!system_configuration_reg.internal_ram_enable && cpu_addr_i <= `SCMD_PRAM_HI)
      |-> (mem_select_o == SEG_EXT))
      else $error("disabled RAM still decoded");
   a_quiet_bus: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
      (cpu_rst_n_o && !fetching_ext && mem_select_o != SEG_EXT &&
       system_configuration_reg.external_bus_quiet)
      |=> (ext_pins_o.data_oe_n && ext_pins_o.strobe_oe_n))
      else $error("external pins driven on quiet internal access");
   a_cfg_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
      (state_reg == FS_READ && wait_reg == 3'h0 && rpin_s2)
      |=> (system_configuration_reg == $past(fetch_data)))
      else $error("configuration byte not loaded");
   a_cpu_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R21
      $rose(cpu_rst_n_o) |-> $past(state_reg == FS_READ && wait_reg == 3'h0))
      else $error("processor released before load");
   a_fast_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
      ($rose(rst_n_i) || $rose(rpin_s2)) |-> cpu_fast_flag)
      else $error("reset did not select fast mode");
   a_ext_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
      (state_reg == FS_REQ && src_ext_reg && rpin_s2)
      |=> (!ext_pins_o.output_enable_n && ext_pins_o.addr == `SCMD_FETCH_ADDR))
      else $error("external fetch not started");
   a_apb_err: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (psel_i && penable_i && !hit_any) |-> (pslverr_o && pready_o))
      else $error("unmapped access not refused");
   a_drive_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R18
      (cpu_rst_n_o && !fetching_ext && mem_select_o != SEG_EXT && cpu_wr_i &&
       !system_configuration_reg.external_bus_quiet)
      |=> (!ext_pins_o.data_oe_n && !ext_pins_o.strobe_oe_n))
      else $error("external pins floated on driven internal access");
   a_mf_normal: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
      system_configuration_reg.multifunction_pin_mode |-> !mf_bus_mode_o)
      else $error("normal mode bit did not release bus mode");
   a_rom_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R17
      (!system_configuration_reg.internal_rom_enable && cpu_addr_i >= `SCMD_PROM_LO &&
       cpu_addr_i <= `SCMD_PROM_HI) |-> (mem_select_o == SEG_EXT))
      else $error("disabled ROM still decoded");
endmodule

// File: tb/scmd_ext_mem.sv
`timescale 1ns/100ps
module scmd_ext_mem import scmd_pkg::*; #(
   parameter logic [7:0] CODE = 8'hAB
) (
   input  wire logic           clk_i,
   input  wire scmd_ext_pins_t pins_i,
   output logic [7:0]          data_o
);
   initial data_o = 8'h00;

   // Outside a read the bus floats, so the value is made to change every cycle.
   always @(posedge clk_i) begin
      if (!pins_i.output_enable_n && pins_i.data_oe_n) begin
         data_o <= (pins_i.addr == 24'h00FFF9) ? CODE : ~pins_i.addr[7:0];
      end else begin
         data_o <= ~data_o;
      end
   end
endmodule

// File: tb/test_sys_config_mem_decode.sv
`timescale 1ns/100ps
module test_sys_config_mem_decode import scmd_pkg::*;;
   logic           clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic           test_pin = 1'b1, int_req = 1'b0, tram = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0;
   logic [15:0]    paddr = 16'h0000;
   logic [31:0]    pwdata = 32'h0, prdata, rd;
   logic [23:0]    cpu_addr = 24'h0, rom_addr;
   logic [7:0]     cpu_wdata = 8'h3C, rom_data = 8'h00, ext_data;
   logic           pready, pslverr, err, drive_n, rom_rd, cpu_rst_n, cpu_en, cpu_clk_en;
   logic           per_clk_en, mf_bus;
   wire logic      pin_n;
   scmd_ext_pins_t pins;
   scmd_seg_t      sel;
   scmd_cfg_t      cfg;
   int             n_fail = 0, samples_checked = 0, cyc = 0;

   always #20 clk = ~clk;
   // Open-drain reset pin with pull-up: low only while the device pulls it.
   assign pin_n = drive_n;

   scmd_top u_scmd_top (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .reset_pin_n_i(pin_n), .reset_pin_n_o(),
      .reset_pin_drive_n_o(drive_n), .test_pin_i(test_pin), .int_reset_req_i(int_req),
      .text_ram_enable_i(tram), .cpu_addr_i(cpu_addr), .cpu_rd_i(cpu_rd), .cpu_wr_i(cpu_wr),
      .cpu_wdata_i(cpu_wdata), .boot_rom_data_i(rom_data), .boot_rom_rd_o(rom_rd),
      .boot_rom_addr_o(rom_addr), .ext_data_bus_i(ext_data), .ext_pins_o(pins),
      .mem_select_o(sel), .cfg_o(cfg), .cpu_rst_n_o(cpu_rst_n), .cpu_enable_o(cpu_en),
      .cpu_clk_en_o(cpu_clk_en), .periph_clk_en_o(per_clk_en), .mf_bus_mode_o(mf_bus));

   scmd_ext_mem u_scmd_ext_mem (.clk_i(clk), .pins_i(pins), .data_o(ext_data));

   always @(posedge clk) begin
      if (rom_rd) begin
         rom_data <= (rom_addr === 24'h00FFF9) ? 8'h9F : 8'h00;
      end
   end

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse(input int n);
      int k;
      k = 0;
      while (drive_n !== 1'b0 && k < 100) begin
         @(negedge clk);
         k++;
      end
      k = 0;
      while (drive_n === 1'b0 && k < 5000) begin
         @(negedge clk);
         k++;
      end
      chk("pulse_len", n, k);
   endtask

   task automatic boot(input logic [7:0] code);
      int k;
      k = 0;
      while (cpu_rst_n !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      chk("cfg_loaded", {24'h0, code}, {24'h0, cfg});
   endtask

   task automatic sel_chk(input logic [23:0] a, input scmd_seg_t s);
      @(posedge clk);
      cpu_addr <= a;
      @(negedge clk);
      chk("mem_select", {29'h0, s}, {29'h0, sel});
   endtask

   task automatic t_regs();
      apb(1'b0, 16'h7C04, 32'h0);
      chk("cfg_read", 32'hAB, rd);
      chk("cpu_en", 32'h1, {31'h0, cpu_en});
      apb(1'b1, 16'h7C04, 32'h5A);
      apb(1'b0, 16'h7C04, 32'h0);
      chk("cfg_rw", 32'h5A, rd);
      chk("cpu_off", 32'h0, {31'h0, cpu_en});
      apb(1'b0, 16'h7C24, 32'h0);
      chk("fast_rst", 32'h40, rd);
      apb(1'b1, 16'h7C08, 32'hFF);
      chk("unmapped_err", 32'h1, {31'h0, err});
      apb(1'b0, 16'h7C08, 32'h0);
      chk("unmapped_rd", 32'h0, rd);
   endtask

   task automatic t_decode();
      apb(1'b1, 16'h7C04, 32'hFF);
      tram <= 1'b1;
      sel_chk(24'h000FFF, SEG_PRAM);
      sel_chk(24'h001000, SEG_EXT);
      sel_chk(24'h001E00, SEG_IO);
      sel_chk(24'h0023FF, SEG_BOOT);
      sel_chk(24'h019FFF, SEG_PROM);
      sel_chk(24'h0A3FFF, SEG_TEXT);
      sel_chk(24'h0A4000, SEG_EXT);
      apb(1'b1, 16'h7C04, 32'h09);
      sel_chk(24'h000010, SEG_EXT);
      sel_chk(24'h002400, SEG_EXT);
      apb(1'b1, 16'h7C04, 32'h06);
      tram <= 1'b0;
      sel_chk(24'h002400, SEG_TROM);
      sel_chk(24'h000010, SEG_PRAM);
      sel_chk(24'h0A0000, SEG_EXT);
   endtask

   task automatic t_quiet(input logic [7:0] c, input logic [1:0] exp);
      apb(1'b1, 16'h7C04, {24'h0, c});
      cpu_addr <= 24'h000100;
      cpu_wr <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("pin_enables", {30'h0, exp}, {30'h0, pins.data_oe_n, pins.strobe_oe_n});
      chk("ext_access", 32'h0000_0100, {7'h0, pins.write_strobe_n, pins.addr});
      @(posedge clk);
      cpu_wr <= 1'b0;
   endtask

   task automatic t_mf(input logic [7:0] c, input logic t, input logic exp);
      apb(1'b1, 16'h7C04, {24'h0, c});
      test_pin <= t;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("mf_bus", {31'h0, exp}, {31'h0, mf_bus});
   endtask

   task automatic t_slow();
      int k;
      int n;
      int z;
      apb(1'b1, 16'h7C24, 32'h0);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (cpu_clk_en !== 1'b0 && k < 300);
      chk("slow_delay", 32'h1, {31'h0, k <= 257});
      n = 0;
      z = 0;
      repeat (512) begin
         @(negedge clk);
         n += (cpu_clk_en === 1'b1);
         z += (per_clk_en !== 1'b1);
      end
      chk("slow_rate", 32'd2, n);
      chk("periph_clk", 32'd0, z);
      apb(1'b1, 16'h7C24, 32'h40);
      @(negedge clk);
      chk("fast_now", 32'h1, {31'h0, cpu_clk_en});
   endtask

   task automatic t_intrst(input logic t, input logic [7:0] c, input int n,
                           input logic [7:0] code);
      apb(1'b1, 16'h7C04, {24'h0, c});
      apb(1'b1, 16'h7C24, 32'h0);
      test_pin <= t;
      repeat (4) @(posedge clk);
      int_req <= 1'b1;
      @(posedge clk);
      int_req <= 1'b0;
      pulse(n);
      boot(code);
      apb(1'b0, 16'h7C24, 32'h0);
      chk("fast_after_rst", 32'h40, rd);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("cfg_preload", 32'hFF, {24'h0, cfg});
      chk("cpu_held", 32'h0, {31'h0, cpu_rst_n});
      @(posedge clk);
      rst_n <= 1'b1;
      pulse(16);
      boot(8'hAB);
      t_regs();
      t_decode();
      t_quiet(8'h22, 2'b11);
      t_quiet(8'h02, 2'b00);
      t_mf(8'h40, 1'b0, 1'b1);
      t_mf(8'h40, 1'b1, 1'b0);
      t_mf(8'h00, 1'b1, 1'b1);
      t_mf(8'h10, 1'b0, 1'b0);
      t_slow();
      t_intrst(1'b0, 8'h1F, 4095, 8'h9F);
      t_intrst(1'b1, 8'h1F, 16, 8'hAB);
      t_intrst(1'b1, 8'h9F, 4095, 8'hAB);
      end_of_test();
   end
endmodule
